// ===== inc/scru_defs.vh
// Constants for the stack, call and return unit: opcodes, operation codes,
// clock counts per bus variant and stack displacements.
// Assumes inclusion by bare name from the core design file.
`ifndef SCRU_DEFS_VH
`define SCRU_DEFS_VH

// Operation codes given by the decoder
`define SCRU_OP_CALLF_MEM 4'h0
`define SCRU_OP_RET_NEAR 4'h1
`define SCRU_OP_RET_NEAR_ADJ 4'h2
`define SCRU_OP_RET_FAR 4'h3
`define SCRU_OP_RET_FAR_ADJ 4'h4
`define SCRU_OP_PUSH_MEM 4'h5
`define SCRU_OP_PUSH_REG 4'h6
`define SCRU_OP_PUSH_SEG 4'h7
`define SCRU_OP_PUSH_FLAGS 4'h8
`define SCRU_OP_PUSH_ALL 4'h9
`define SCRU_OP_PUSH_IMM8 4'ha
`define SCRU_OP_PUSH_IMM16 4'hb
`define SCRU_OP_POP_MEM 4'hc
`define SCRU_OP_POP_REG 4'hd
`define SCRU_OP_POP_SEG 4'he

// First opcode bytes named by the instruction set
`define SCRU_OPC_RET_NEAR_ADJ 8'hc2
`define SCRU_OPC_RET_FAR 8'hcb
`define SCRU_OPC_POP_MEM 8'h8f

// Clock counts: slow = 8-bit bus or odd address, fast = 16-bit bus even; the unit picks the count by bus width only
`define SCRU_CLK_CALLF_S 7'h2f
`define SCRU_CLK_CALLF_F 7'h1f
`define SCRU_CLK_RETN_S 7'h13
`define SCRU_CLK_RETN_F 7'h0f
`define SCRU_CLK_RETNA_S 7'h18
`define SCRU_CLK_RETNA_F 7'h14
`define SCRU_CLK_RETF_S 7'h1d
`define SCRU_CLK_RETF_F 7'h15
`define SCRU_CLK_RETFA_S 7'h20
`define SCRU_CLK_RETFA_F 7'h18
`define SCRU_CLK_PUSHM_S 7'h1a
`define SCRU_CLK_PUSHM_F 7'h12
`define SCRU_CLK_PUSH1_S 7'h0c
`define SCRU_CLK_PUSH1_F 7'h08
`define SCRU_CLK_PUSHA_S 7'h43
`define SCRU_CLK_PUSHA_F 7'h23
`define SCRU_CLK_PUSHI8_S 7'h0b
`define SCRU_CLK_PUSHI8_F 7'h07
`define SCRU_CLK_POPM_S 7'h19
`define SCRU_CLK_POPM_F 7'h11

// Stack displacements in bytes
`define SCRU_STEP_WORD 16'h0002
`define SCRU_STEP_FAR 16'h0004
`define SCRU_STEP_ALL 16'h0010

// Register-set push slot count
`define SCRU_ALL_SLOTS 4'h8
`define SCRU_SLOT_SP 4'h4
`endif

// ===== core/scru_stack_unit.v
// Stack and procedure-linkage execution unit: far indirect call, returns,
// push and pop forms, with per-variant clock counts.
// Assumes a decoder handing one operation at a time with operands, and a bus
// unit that takes one word transfer per request and acknowledges it.
`timescale 1ns/10ps
`include "scru_defs.vh"

module scru_stack_unit #(
   parameter WORD_W = 16
) (
   input wire ref_clk,
   input wire rstn,
   // Decoder side
   input wire op_valid,
   output wire op_ready,
   input wire [3:0] op_code,
   input wire bus_16bit,
   input wire [WORD_W-1:0] imm_word,
   input wire [WORD_W-1:0] mem_addr,
   input wire [WORD_W-1:0] src_word,
   input wire [1:0] seg_sel,
   input wire [WORD_W-1:0] stack_top_pointer,
   input wire [WORD_W-1:0] code_segment_base,
   input wire [WORD_W-1:0] instruction_offset,
   input wire [WORD_W-1:0] flag_status_word,
   input wire [WORD_W-1:0] accumulator_word,
   input wire [WORD_W-1:0] count_word_reg,
   input wire [WORD_W-1:0] data_word_reg,
   input wire [WORD_W-1:0] base_word_reg,
   input wire [WORD_W-1:0] frame_base_pointer,
   input wire [WORD_W-1:0] source_index_reg,
   input wire [WORD_W-1:0] dest_index_reg,
   // Results
   output reg done_r,
   output reg [WORD_W-1:0] new_sp_r,
   output reg sp_we_r,
   output reg [WORD_W-1:0] new_cs_r,
   output reg cs_we_r,
   output reg [WORD_W-1:0] new_ip_r,
   output reg ip_we_r,
   output reg [WORD_W-1:0] pop_data_r,
   output reg reg_we_r,
   output reg seg_we_r,
   output reg [1:0] seg_sel_r,
   output reg irq_hold_r,
   // Bus unit side: one word per request
   output reg bus_req_r,
   output reg bus_write_r,
   output reg bus_stack_r,
   output reg [WORD_W-1:0] bus_addr_r,
   output reg [WORD_W-1:0] bus_wdata_r,
   input wire bus_ack,
   input wire [WORD_W-1:0] bus_rdata
);

   // States, one-hot, and the code segment selector value
   localparam S_IDLE = 4'b0001;
   localparam S_XFER = 4'b0010;
   localparam S_WAIT = 4'b0100;
   localparam S_DONE = 4'b1000;
   localparam SEG_CODE = 2'b01;

   // Reset release through two flops
   reg rst_s1_r;
   reg rst_s2_r;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire rst_n = rst_s2_r;

   reg [3:0] state_r;
   reg [3:0] op_r;
   reg [3:0] step_r;
   reg [6:0] cyc_r;
   reg [6:0] budget_r;
   reg [WORD_W-1:0] sp0_r;
   reg [WORD_W-1:0] tmp_r;
   reg [WORD_W-1:0] imm_r;
   reg [WORD_W-1:0] maddr_r;
   reg [WORD_W-1:0] all_r [0:7];

   // Clock budget by operation and bus variant; the address is not looked at, so odd addresses on a 16-bit bus get the fast count
   function [6:0] clk_budget;
      input [3:0] op;
      input fast;
      begin
         case (op)
            `SCRU_OP_CALLF_MEM: clk_budget = fast ? `SCRU_CLK_CALLF_F : `SCRU_CLK_CALLF_S;
            `SCRU_OP_RET_NEAR: clk_budget = fast ? `SCRU_CLK_RETN_F : `SCRU_CLK_RETN_S;
            `SCRU_OP_RET_NEAR_ADJ: clk_budget = fast ? `SCRU_CLK_RETNA_F : `SCRU_CLK_RETNA_S;
            `SCRU_OP_RET_FAR: clk_budget = fast ? `SCRU_CLK_RETF_F : `SCRU_CLK_RETF_S;
            `SCRU_OP_RET_FAR_ADJ: clk_budget = fast ? `SCRU_CLK_RETFA_F : `SCRU_CLK_RETFA_S;
            `SCRU_OP_PUSH_MEM: clk_budget = fast ? `SCRU_CLK_PUSHM_F : `SCRU_CLK_PUSHM_S;
            `SCRU_OP_PUSH_ALL: clk_budget = fast ? `SCRU_CLK_PUSHA_F : `SCRU_CLK_PUSHA_S;
            `SCRU_OP_PUSH_IMM8: clk_budget = fast ? `SCRU_CLK_PUSHI8_F : `SCRU_CLK_PUSHI8_S;
            `SCRU_OP_POP_MEM: clk_budget = fast ? `SCRU_CLK_POPM_F : `SCRU_CLK_POPM_S;
            default: clk_budget = fast ? `SCRU_CLK_PUSH1_F : `SCRU_CLK_PUSH1_S;
         endcase
      end
   endfunction

   // Number of word transfers per operation
   function [3:0] xfer_count;
      input [3:0] op;
      begin
         case (op)
            `SCRU_OP_CALLF_MEM: xfer_count = 4'h4;
            `SCRU_OP_RET_FAR, `SCRU_OP_RET_FAR_ADJ, `SCRU_OP_PUSH_MEM,
            `SCRU_OP_POP_MEM: xfer_count = 4'h2;
            `SCRU_OP_PUSH_ALL: xfer_count = `SCRU_ALL_SLOTS;
            default: xfer_count = 4'h1;
         endcase
      end
   endfunction

   wire is_push1 = (op_r == `SCRU_OP_PUSH_REG) || (op_r == `SCRU_OP_PUSH_SEG) ||
                   (op_r == `SCRU_OP_PUSH_FLAGS) || (op_r == `SCRU_OP_PUSH_IMM8) ||
                   (op_r == `SCRU_OP_PUSH_IMM16);
   wire [WORD_W-1:0] sp_dn2 = sp0_r - `SCRU_STEP_WORD;
   wire [WORD_W-1:0] sp_dn4 = sp0_r - `SCRU_STEP_FAR;
   wire [WORD_W-1:0] sp_up2 = sp0_r + `SCRU_STEP_WORD;
   wire [WORD_W-1:0] all_addr = sp0_r - {{(WORD_W-5){1'b0}}, step_r, 1'b0} - `SCRU_STEP_WORD;

   // Request for the current step: address of low byte, high byte above it
   reg nx_write;
   reg [WORD_W-1:0] nx_addr;
   reg [WORD_W-1:0] nx_data;
   reg nx_stack;
   always @* begin
      nx_write = 1'b0;
      nx_addr = sp0_r;
      nx_data = tmp_r;
      nx_stack = 1'b1;
      case (op_r)
         `SCRU_OP_CALLF_MEM: begin
            // Fetch pointer words, then push segment above offset
            case (step_r)
               4'h0: begin nx_addr = maddr_r; nx_stack = 1'b0; end
               4'h1: begin nx_addr = maddr_r + `SCRU_STEP_WORD; nx_stack = 1'b0; end
               4'h2: begin nx_write = 1'b1; nx_addr = sp_dn2; nx_data = code_segment_base; end
               default: begin nx_write = 1'b1; nx_addr = sp_dn4; nx_data = instruction_offset; end
            endcase
         end
         `SCRU_OP_RET_FAR, `SCRU_OP_RET_FAR_ADJ:
            nx_addr = (step_r == 4'h0) ? sp0_r : sp_up2;
         `SCRU_OP_PUSH_MEM: begin
            nx_stack = (step_r != 4'h0);
            nx_write = (step_r != 4'h0);
            nx_addr = (step_r == 4'h0) ? maddr_r : sp_dn2;
         end
         `SCRU_OP_POP_MEM: begin
            nx_stack = (step_r == 4'h0);
            nx_write = (step_r != 4'h0);
            nx_addr = (step_r == 4'h0) ? sp0_r : maddr_r;
         end
         `SCRU_OP_PUSH_ALL: begin
            nx_write = 1'b1;
            nx_addr = all_addr;
            nx_data = all_r[step_r[2:0]];
         end
         default: begin
            if (is_push1) begin
               nx_write = 1'b1;
               nx_addr = sp_dn2;
               nx_data = imm_r;
            end
         end
      endcase
   end

   assign op_ready = (state_r == S_IDLE);

   // Operand capture: pushed word chosen at acceptance
   reg [WORD_W-1:0] cap_word;
   always @* begin
      case (op_code)
         `SCRU_OP_PUSH_FLAGS: cap_word = flag_status_word;
         `SCRU_OP_PUSH_IMM8: cap_word = {{(WORD_W-8){imm_word[7]}}, imm_word[7:0]};
         // Returns with adjustment keep their pop-value here
         `SCRU_OP_RET_NEAR_ADJ, `SCRU_OP_RET_FAR_ADJ: cap_word = imm_word;
         `SCRU_OP_PUSH_IMM16: cap_word = imm_word;
         default: cap_word = src_word;
      endcase
   end

   // Main sequencer; budget counter pads each operation to its clock count
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         op_r <= 4'h0;
         step_r <= 4'h0;
         cyc_r <= 7'h00;
         budget_r <= 7'h00;
         sp0_r <= {WORD_W{1'b0}};
         tmp_r <= {WORD_W{1'b0}};
         imm_r <= {WORD_W{1'b0}};
         maddr_r <= {WORD_W{1'b0}};
         done_r <= 1'b0;
         new_sp_r <= {WORD_W{1'b0}};
         sp_we_r <= 1'b0;
         new_cs_r <= {WORD_W{1'b0}};
         cs_we_r <= 1'b0;
         new_ip_r <= {WORD_W{1'b0}};
         ip_we_r <= 1'b0;
         pop_data_r <= {WORD_W{1'b0}};
         reg_we_r <= 1'b0;
         seg_we_r <= 1'b0;
         seg_sel_r <= 2'b00;
         irq_hold_r <= 1'b0;
         bus_req_r <= 1'b0;
         bus_write_r <= 1'b0;
         bus_stack_r <= 1'b0;
         bus_addr_r <= {WORD_W{1'b0}};
         bus_wdata_r <= {WORD_W{1'b0}};
      end else begin
         done_r <= 1'b0;
         sp_we_r <= 1'b0;
         cs_we_r <= 1'b0;
         ip_we_r <= 1'b0;
         reg_we_r <= 1'b0;
         seg_we_r <= 1'b0;
         if (state_r != S_IDLE)
            cyc_r <= cyc_r + 7'h01;
         case (state_r)
            S_IDLE: begin
               if (op_valid) begin
                  op_r <= op_code;
                  step_r <= 4'h0;
                  cyc_r <= 7'h01;
                  budget_r <= clk_budget(op_code, bus_16bit);
                  sp0_r <= stack_top_pointer;
                  imm_r <= cap_word;
                  maddr_r <= mem_addr;
                  seg_sel_r <= seg_sel;
                  // Interrupt hold ends once the following instruction starts
                  irq_hold_r <= 1'b0;
                  // Snapshot order: old pointer goes in slot four
                  all_r[0] <= accumulator_word;
                  all_r[1] <= count_word_reg;
                  all_r[2] <= data_word_reg;
                  all_r[3] <= base_word_reg;
                  all_r[4] <= stack_top_pointer;
                  all_r[5] <= frame_base_pointer;
                  all_r[6] <= source_index_reg;
                  all_r[7] <= dest_index_reg;
                  state_r <= S_XFER;
               end
            end
            S_XFER: begin
               bus_req_r <= 1'b1;
               bus_write_r <= nx_write;
               bus_stack_r <= nx_stack;
               bus_addr_r <= nx_addr;
               bus_wdata_r <= nx_data;
               state_r <= S_WAIT;
            end
            S_WAIT: begin
               if (bus_ack) begin
                  bus_req_r <= 1'b0;
                  if (!bus_write_r) begin
                     tmp_r <= bus_rdata;
                     // Far call keeps the pointer halves until the pushes end
                     if (op_r == `SCRU_OP_CALLF_MEM && step_r == 4'h0)
                        new_ip_r <= bus_rdata;
                     if (op_r == `SCRU_OP_CALLF_MEM && step_r == 4'h1)
                        new_cs_r <= bus_rdata;
                     if (op_r == `SCRU_OP_RET_NEAR || op_r == `SCRU_OP_RET_NEAR_ADJ ||
                         ((op_r == `SCRU_OP_RET_FAR || op_r == `SCRU_OP_RET_FAR_ADJ) &&
                          step_r == 4'h0))
                        new_ip_r <= bus_rdata;
                     if ((op_r == `SCRU_OP_RET_FAR || op_r == `SCRU_OP_RET_FAR_ADJ) &&
                         step_r == 4'h1)
                        new_cs_r <= bus_rdata;
                     pop_data_r <= bus_rdata;
                  end
                  if (step_r + 4'h1 == xfer_count(op_r)) begin
                     state_r <= S_DONE;
                  end else begin
                     step_r <= step_r + 4'h1;
                     state_r <= S_XFER;
                  end
               end
            end
            S_DONE: begin
               // Hold completion until the documented clock count is reached
               if (cyc_r >= budget_r) begin
                  done_r <= 1'b1;
                  sp_we_r <= 1'b1;
                  state_r <= S_IDLE;
                  case (op_r)
                     `SCRU_OP_CALLF_MEM: begin
                        new_sp_r <= sp_dn4;
                        cs_we_r <= 1'b1;
                        ip_we_r <= 1'b1;
                     end
                     `SCRU_OP_RET_NEAR: begin
                        new_sp_r <= sp_up2;
                        ip_we_r <= 1'b1;
                     end
                     `SCRU_OP_RET_NEAR_ADJ: begin
                        new_sp_r <= sp_up2 + imm_r;
                        ip_we_r <= 1'b1;
                     end
                     `SCRU_OP_RET_FAR: begin
                        new_sp_r <= sp0_r + `SCRU_STEP_FAR;
                        cs_we_r <= 1'b1;
                        ip_we_r <= 1'b1;
                     end
                     `SCRU_OP_RET_FAR_ADJ: begin
                        new_sp_r <= sp0_r + `SCRU_STEP_FAR + imm_r;
                        cs_we_r <= 1'b1;
                        ip_we_r <= 1'b1;
                     end
                     `SCRU_OP_PUSH_ALL:
                        new_sp_r <= sp0_r - `SCRU_STEP_ALL;
                     `SCRU_OP_POP_MEM:
                        new_sp_r <= sp_up2;
                     `SCRU_OP_POP_REG: begin
                        new_sp_r <= sp_up2;
                        reg_we_r <= 1'b1;
                     end
                     `SCRU_OP_POP_SEG: begin
                        new_sp_r <= sp_up2;
                        // Code segment cannot be loaded this way
                        seg_we_r <= (seg_sel_r != SEG_CODE);
                        irq_hold_r <= 1'b1;
                     end
                     default:
                        new_sp_r <= sp_dn2;
                  endcase
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

endmodule // scru_stack_unit

// ===== bench/scru_mem_model.sv
// Stack memory behind the bus unit: byte array, one word per request.
// Assumes the unit holds each request until it sees bus_ack.
`timescale 1ns/10ps
module scru_mem_model (
   input wire ref_clk,
   input wire bus_req_r,
   input wire bus_write_r,
   input wire [15:0] bus_addr_r,
   input wire [15:0] bus_wdata_r,
   input wire [3:0] lag,
   output logic bus_ack,
   output wire [15:0] bus_rdata
);
   logic [7:0] mem [logic [15:0]];
   logic [3:0] cnt = 4'h0;
   logic [15:0] last = 16'h0000;
   initial bus_ack = 1'b0;
   // Idle data shows the inverse of the last word, so stale reads cannot pass
   assign bus_rdata = bus_ack ? last : ~last;
   // Answer after lag extra cycles; ack is a one-cycle pulse
   always @(posedge ref_clk) begin
      if (bus_ack) begin
         bus_ack <= 1'b0;
      end else if (bus_req_r && cnt < lag) begin
         cnt <= cnt + 4'h1;
      end else if (bus_req_r) begin
         cnt <= 4'h0;
         bus_ack <= 1'b1;
         if (bus_write_r) begin
            wr(bus_addr_r, bus_wdata_r);
         end else begin
            last <= rd(bus_addr_r);
         end
      end
   end
   function automatic logic [15:0] rd(input logic [15:0] a);
      return {mem[a + 16'h0001], mem[a]};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      mem[a] = d[7:0];
      mem[a + 16'h0001] = d[15:8];
   endtask
endmodule // scru_mem_model

// ===== bench/scru_stack_unit_checker.sv
// Timing and stack pointer checks for the stack unit, bound to its ports.
// Assumes operands are stable at the accepting edge.
`timescale 1ns/10ps
`include "scru_defs.vh"
module scru_stack_unit_checker #(
   parameter WORD_W = 16
) (
   input wire ref_clk,
   input wire rstn,
   input wire op_valid,
   input wire op_ready,
   input wire [3:0] op_code,
   input wire [WORD_W-1:0] imm_word,
   input wire [1:0] seg_sel,
   input wire [WORD_W-1:0] stack_top_pointer,
   input wire done_r,
   input wire [WORD_W-1:0] new_sp_r,
   input wire sp_we_r,
   input wire seg_we_r,
   input wire [1:0] seg_sel_r,
   input wire irq_hold_r,
   input wire bus_req_r,
   input wire bus_write_r,
   input wire bus_stack_r,
   input wire [WORD_W-1:0] bus_addr_r,
   input wire [WORD_W-1:0] bus_wdata_r,
   input wire bus_ack
);
   reg [3:0] op_q_r;
   reg [1:0] sel_q_r;
   reg [WORD_W-1:0] sp_q_r;
   reg [WORD_W-1:0] imm_q_r;
   wire one_push;
   // Operands of the running operation, kept from its accept edge
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         op_q_r <= 4'h0;
         sel_q_r <= 2'h0;
         sp_q_r <= {WORD_W{1'b0}};
         imm_q_r <= {WORD_W{1'b0}};
      end else if (op_valid && op_ready) begin
         op_q_r <= op_code;
         sel_q_r <= seg_sel;
         sp_q_r <= stack_top_pointer;
         imm_q_r <= imm_word;
      end
   end
   assign one_push = op_q_r >= 4'h5 && op_q_r <= 4'hb && op_q_r != 4'h9;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   chk_req_hold: assert property (bus_req_r && !bus_ack |=> bus_req_r && $stable(bus_addr_r)
      && $stable(bus_wdata_r) && $stable(bus_write_r)) else $error("bus request moved early");
   chk_req_drop: assert property (bus_req_r && bus_ack |=> !bus_req_r)
      else $error("bus request not dropped");
   chk_done_pulse: assert property (done_r |=> !done_r) else $error("done longer than one");
   chk_push_sp: assert property (sp_we_r && one_push |-> new_sp_r == sp_q_r - 16'h0002)
      else $error("push pointer wrong");
   chk_push_addr: assert property ($rose(bus_req_r) && bus_write_r && one_push
      |-> bus_stack_r && bus_addr_r == sp_q_r - 16'h0002) else $error("push address wrong");
   chk_all_sp: assert property (sp_we_r && op_q_r == `SCRU_OP_PUSH_ALL
      |-> new_sp_r == sp_q_r - 16'h0010) else $error("push-all pointer wrong");
   chk_call_sp: assert property (sp_we_r && op_q_r == `SCRU_OP_CALLF_MEM
      |-> new_sp_r == sp_q_r - 16'h0004) else $error("call pointer wrong");
   chk_ret_sp: assert property (sp_we_r && (op_q_r == 4'h1 || op_q_r == 4'h2)
      |-> new_sp_r == sp_q_r + 16'h0002 + (op_q_r == 4'h2 ? imm_q_r : 16'h0000))
      else $error("near return pointer wrong");
   chk_retf_sp: assert property (sp_we_r && (op_q_r == 4'h3 || op_q_r == 4'h4)
      |-> new_sp_r == sp_q_r + 16'h0004 + (op_q_r == 4'h4 ? imm_q_r : 16'h0000))
      else $error("far return pointer wrong");
   chk_pop_sp: assert property (sp_we_r && op_q_r >= 4'hc
      |-> new_sp_r == sp_q_r + 16'h0002) else $error("pop pointer wrong");
   chk_seg_nocs: assert property (seg_we_r |-> seg_sel_r != 2'b01)
      else $error("code segment loaded by pop");
   chk_irq_set: assert property (done_r && op_q_r == `SCRU_OP_POP_SEG && sel_q_r != 2'b01
      |-> ##[0:1] irq_hold_r) else $error("interrupt hold not set");
   chk_irq_clr: assert property (op_valid && op_ready |-> ##[1:2] !irq_hold_r)
      else $error("interrupt hold not cleared");
endmodule // scru_stack_unit_checker
bind scru_stack_unit scru_stack_unit_checker #(.WORD_W(WORD_W)) u_chk (.ref_clk(ref_clk),
   .rstn(rstn), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
   .imm_word(imm_word), .seg_sel(seg_sel), .stack_top_pointer(stack_top_pointer),
   .done_r(done_r), .new_sp_r(new_sp_r), .sp_we_r(sp_we_r), .seg_we_r(seg_we_r),
   .seg_sel_r(seg_sel_r), .irq_hold_r(irq_hold_r), .bus_req_r(bus_req_r),
   .bus_write_r(bus_write_r), .bus_stack_r(bus_stack_r), .bus_addr_r(bus_addr_r),
   .bus_wdata_r(bus_wdata_r), .bus_ack(bus_ack));

// ===== bench/scru_stack_unit_bench.sv
// Self-checking bench for the stack unit with a memory model on its bus side.
// Assumes the bus answers at once unless lag is raised.
`timescale 1ns/10ps
`include "scru_defs.vh"
module scru_stack_unit_bench;
   reg ref_clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, bus_16bit = 1'b0;
   reg [3:0] op_code = 4'h0, lag = 4'h0;
   reg [1:0] seg_sel = 2'h0;
   reg [15:0] imm_word = 16'h0000, mem_addr = 16'h0000, src_word = 16'ha5a5;
   reg [15:0] stack_top_pointer = 16'h0000, code_segment_base = 16'h0000;
   reg [15:0] instruction_offset = 16'h0000, flag_status_word = 16'hf0f2;
   reg [15:0] accumulator_word = 16'h0a0a, count_word_reg = 16'h0c0c, data_word_reg = 16'h0d0d;
   reg [15:0] base_word_reg = 16'h0b0b, frame_base_pointer = 16'h0e0e;
   reg [15:0] source_index_reg = 16'h0101, dest_index_reg = 16'h0202;
   wire op_ready, done_r, sp_we_r, cs_we_r, ip_we_r, reg_we_r, seg_we_r, irq_hold_r;
   wire bus_req_r, bus_write_r, bus_stack_r, bus_ack;
   wire [1:0] seg_sel_r;
   wire [15:0] new_sp_r, new_cs_r, new_ip_r, pop_data_r, bus_addr_r, bus_wdata_r, bus_rdata;
   int n_checks = 0, n_mismatch = 0;
   scru_stack_unit dut (.ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid),
      .op_ready(op_ready), .op_code(op_code), .bus_16bit(bus_16bit), .imm_word(imm_word),
      .mem_addr(mem_addr), .src_word(src_word), .seg_sel(seg_sel),
      .stack_top_pointer(stack_top_pointer), .code_segment_base(code_segment_base),
      .instruction_offset(instruction_offset), .flag_status_word(flag_status_word),
      .accumulator_word(accumulator_word), .count_word_reg(count_word_reg),
      .data_word_reg(data_word_reg), .base_word_reg(base_word_reg),
      .frame_base_pointer(frame_base_pointer), .source_index_reg(source_index_reg),
      .dest_index_reg(dest_index_reg), .done_r(done_r), .new_sp_r(new_sp_r),
      .sp_we_r(sp_we_r), .new_cs_r(new_cs_r), .cs_we_r(cs_we_r), .new_ip_r(new_ip_r),
      .ip_we_r(ip_we_r), .pop_data_r(pop_data_r), .reg_we_r(reg_we_r), .seg_we_r(seg_we_r),
      .seg_sel_r(seg_sel_r), .irq_hold_r(irq_hold_r), .bus_req_r(bus_req_r),
      .bus_write_r(bus_write_r), .bus_stack_r(bus_stack_r), .bus_addr_r(bus_addr_r),
      .bus_wdata_r(bus_wdata_r), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
   scru_mem_model mdl (.ref_clk(ref_clk), .bus_req_r(bus_req_r), .bus_write_r(bus_write_r),
      .bus_addr_r(bus_addr_r), .bus_wdata_r(bus_wdata_r), .lag(lag), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata));
   always #5 ref_clk = ~ref_clk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Offer one operation; count edges from acceptance to the done pulse
   task automatic run(input logic [3:0] code, input logic fast, output logic [15:0] cyc);
      @(negedge ref_clk);
      op_code = code;
      bus_16bit = fast;
      op_valid = 1'b1;
      @(negedge ref_clk);
      op_valid = 1'b0;
      cyc = 16'h0000;
      while (done_r !== 1'b1 && cyc < 16'd300) begin
         @(negedge ref_clk);
         cyc++;
      end
   endtask
   task automatic t_call();
      logic [15:0] c;
      for (int f = 0; f < 2; f++) begin
         stack_top_pointer = 16'h0800;
         mem_addr = 16'h0300;
         code_segment_base = 16'h1234;
         instruction_offset = 16'h5678;
         mdl.wr(16'h0300, 16'hbeef);
         mdl.wr(16'h0302, 16'hcafe);
         run(`SCRU_OP_CALLF_MEM, f[0], c);
         chk("call cycles", f ? 16'd31 : 16'd47, c);
         chk("call cs", 16'hcafe, new_cs_r);
         chk("call ip", 16'hbeef, new_ip_r);
         chk("call we", 16'h0003, {14'h0, cs_we_r, ip_we_r});
         chk("saved cs", 16'h1234, mdl.rd(16'h07fe));
         chk("saved ip", 16'h5678, mdl.rd(16'h07fc));
         chk("saved cs low byte", 16'h0034, {8'h00, mdl.mem[16'h07fe]});
      end
   endtask
   task automatic t_ret();
      logic [15:0] sl [4] = '{16'd19, 16'd24, 16'd29, 16'd32};
      logic [15:0] fs [4] = '{16'd15, 16'd20, 16'd21, 16'd24};
      logic [15:0] ds [4] = '{16'd2, 16'd10, 16'd4, 16'd12};
      logic [15:0] c;
      for (int i = 0; i < 8; i++) begin
         stack_top_pointer = 16'h0900;
         imm_word = 16'h0008;
         mdl.wr(16'h0900, 16'h1111);
         mdl.wr(16'h0902, 16'h2222);
         run(4'(i % 4 + 1), i > 3, c);
         chk("ret cycles", i > 3 ? fs[i % 4] : sl[i % 4], c);
         chk("ret ip", 16'h1111, new_ip_r);
         chk("ret we", i % 4 > 1 ? 16'h3 : 16'h1, {14'h0, cs_we_r, ip_we_r});
         chk("ret sp", 16'h0900 + ds[i % 4], new_sp_r);
         if (i % 4 > 1) chk("ret cs", 16'h2222, new_cs_r);
      end
   endtask
   // Byte immediate 85 must widen to ff85 while the word form keeps 4385
   task automatic t_push();
      logic [3:0] op [6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb};
      logic [15:0] ev [6] = '{16'h3c3c, 16'ha5a5, 16'ha5a5, 16'hf0f2, 16'hff85, 16'h4385};
      logic [15:0] sl [6] = '{16'd26, 16'd12, 16'd12, 16'd12, 16'd11, 16'd12};
      logic [15:0] fs [6] = '{16'd18, 16'd8, 16'd8, 16'd8, 16'd7, 16'd8};
      logic [15:0] c;
      for (int i = 0; i < 12; i++) begin
         stack_top_pointer = 16'h0a00;
         mem_addr = 16'h0310;
         imm_word = 16'h4385;
         mdl.wr(16'h0310, 16'h3c3c);
         mdl.wr(16'h09fe, 16'h0000);
         run(op[i % 6], i > 5, c);
         chk("push cycles", i > 5 ? fs[i % 6] : sl[i % 6], c);
         chk("push word", ev[i % 6], mdl.rd(16'h09fe));
         chk("push sp", 16'h09fe, new_sp_r);
      end
   endtask
   // Third pass runs with a slow bus: data must still be right
   task automatic t_all();
      logic [15:0] ev [8] = '{16'h0a0a, 16'h0c0c, 16'h0d0d, 16'h0b0b,
                              16'h0b00, 16'h0e0e, 16'h0101, 16'h0202};
      logic [15:0] c;
      for (int i = 0; i < 3; i++) begin
         stack_top_pointer = 16'h0b00;
         lag = i == 2 ? 4'h2 : 4'h0;
         run(`SCRU_OP_PUSH_ALL, i == 1, c);
         if (i < 2) chk("all cycles", i ? 16'd35 : 16'd67, c);
         for (int k = 0; k < 8; k++)
            chk("all word", ev[k], mdl.rd(16'h0afe - 16'(2 * k)));
         chk("all sp", 16'h0af0, new_sp_r);
      end
      lag = 4'h0;
   endtask
   task automatic t_pop();
      logic [15:0] sl [3] = '{16'd25, 16'd12, 16'd12};
      logic [15:0] fs [3] = '{16'd17, 16'd8, 16'd8};
      logic [15:0] we [3] = '{16'h0, 16'h2, 16'h1};
      logic [15:0] c;
      for (int i = 0; i < 6; i++) begin
         stack_top_pointer = 16'h0c00;
         mem_addr = 16'h0400;
         seg_sel = 2'b10;
         mdl.wr(16'h0c00, 16'h7e50 + 16'(i));
         run(4'(12 + i % 3), i > 2, c);
         chk("pop cycles", i > 2 ? fs[i % 3] : sl[i % 3], c);
         chk("pop sp", 16'h0c02, new_sp_r);
         chk("pop we", we[i % 3], {14'h0, reg_we_r, seg_we_r});
         if (i % 3 == 0) chk("pop mem", 16'h7e50 + 16'(i), mdl.rd(16'h0400));
         else chk("pop data", 16'h7e50 + 16'(i), pop_data_r);
      end
      @(negedge ref_clk);
      chk("irq hold set", 16'h0001, {15'h0, irq_hold_r});
      run(`SCRU_OP_PUSH_REG, 1'b1, c);
      chk("irq hold clear", 16'h0000, {15'h0, irq_hold_r});
      seg_sel = 2'b01;
      run(`SCRU_OP_POP_SEG, 1'b1, c);
      chk("code pop sp", 16'h0c02, new_sp_r);
      chk("code pop we", 16'h0000, {15'h0, seg_we_r});
   endtask
   // Watchdog at 10000 cycles, well beyond the under one thousand cycles the scenarios need
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (5) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (3) @(negedge ref_clk);
      t_call();
      t_ret();
      t_push();
      t_all();
      t_pop();
      give_verdict();
   end
endmodule // scru_stack_unit_bench
